// file: hdl/iicr_regs.sv
// Purpose: Control, status and data registers of a two-wire
//          bus controller, with a compact bit engine
// Assumes: APB slave, zero wait states, open-drain pins
// Notes:   Output enables are active low
//
// Behaviour
// R1: Control bit 7 enables the whole module; the busy flag and APB register access still work while it is clear.
// R2: Control bit 6 gates the interrupt request.
// R3: Master select rising makes start; falling makes stop, back to slave.
// R4: Software sets direction transmit for address, slave per captured bit.
// R5: Receiver acknowledges each byte unless control bit 3 is set; the slave acknowledges a matching address byte even when it is set.
// R6: Writing control bit 2 as master makes repeated start; reads 0.
// R7: Repeated start at wrong time counts as arbitration loss.
// R8: Byte done flag sets per byte; data access in mode clears it.
// R9: Own address or enabled general call sets hit; control write clears.
// R10: Busy sets on any start, clears on any stop.
// R11: Arbitration lost flag sets, cleared by writing one.
// R12: Addressed slave captures calling read/write bit in status bit 2.
// R13: Pending flag sets on byte, hit or loss; write one clears.
// R14: Status bit 0 records sampled acknowledge after transmit byte.
// R15: Master transmit data write shifts byte out, MSB first.
// R16: Master receive data read starts next byte reception.
// R17: Software changes mode before last read leaving master receive.
// R18: After address match slave offers same data behaviour.
// R19: Transfer starts only when direction bit matches access.
// R20: Data reads return last received byte only.
// R21: First byte after master start is sent as address byte.
// R22: General call matches only when second control bit 7 set.
// R23: Acknowledge is data low during the ninth clock.
// R24: Interrupt output is pending flag AND interrupt enable.
//
// Added by the designer: the register offsets and register access over APB.
`default_nettype none
module iicr_regs
	import iicr_pkg::*;
#(
	parameter int QTR = QTR_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n,
	output logic             irq
);
	if (QTR < 4 || QTR > 65535) begin : g_chk
		$error("QTR out of range");
	end

	function automatic logic is_master(input iicr_state_e s);
		is_master = (s == M_START) || (s == M_HOLD) || (s == M_BIT) ||
			(s == M_STOP) || (s == M_RSTART);
	endfunction : is_master

	iicr_state_e st_r;
	logic [1:0]  ph_r;
	logic [3:0]  cnt_r;
	logic [7:0]  sh_r;
	logic [7:0]  rx_r;
	logic [15:0] qcnt_r;
	logic        scl_lo_r, sda_lo_r, adr_r, ack_val_r;
	logic        done_ev_r, hit_ev_r, arb_ev_r, ack_ev_r;
	logic        en_r, ie_r, mst_r, tx_r, ack_suppress_r, gca_r;
	logic [6:0]  own_r;
	logic        tcf_r, own_address_hit_r, busy_r, arbitration_lost_flag_r, srw_r, iif_r, ack_missing_r;
	logic        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic [31:0] prdata_r;

	// ****************
	// APB decode
	// ****************
	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire rd       = acc & ~pwrite;
	wire hit_ctrl = paddr == OFF_CTRL;
	wire hit_stat = paddr == OFF_STAT;
	wire hit_data = paddr == OFF_DATA;
	wire hit_ctl2 = paddr == OFF_CTL2;
	wire hit_own  = paddr == OFF_OWN;
	wire mapped   = hit_ctrl | hit_stat | hit_data | hit_ctl2 | hit_own;
	wire wr_ctrl  = wr & hit_ctrl;
	wire wr_stat  = wr & hit_stat;
	wire wr_data  = wr & hit_data;
	wire rd_data  = rd & hit_data;
	wire mst_rise = wr_ctrl & pwdata[CTRL_MST] & ~mst_r;
	wire mst_fall = wr_ctrl & ~pwdata[CTRL_MST] & mst_r;
	wire repeat_start_request_req = wr_ctrl & pwdata[CTRL_REPEAT_START_REQUEST];

	wire [7:0] ctrl_rd = {en_r, ie_r, mst_r, tx_r, ack_suppress_r, 3'h0};
	wire [7:0] stat_rd = {tcf_r, own_address_hit_r, busy_r, arbitration_lost_flag_r, 1'b0,
		srw_r, iif_r, ack_missing_r};
	wire [7:0] rsel = hit_ctrl ? ctrl_rd :
		hit_stat ? stat_rd :
		hit_data ? rx_r :
		hit_ctl2 ? {gca_r, 7'h00} :
		hit_own  ? {own_r, 1'b0} : 8'h00;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;
	assign prdata  = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_r <= {24'h00_0000, rsel};
	end

	// ****************
	// Pin sync and bus events
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{scl_s1, scl_s2, scl_d} <= 3'h7;
			{sda_s1, sda_s2, sda_d} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
		end
	end

	wire scl_rise  = scl_s2 & ~scl_d;
	wire scl_fall  = ~scl_s2 & scl_d;
	wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_n = ~scl_lo_r;
	assign sda_oe_n = ~sda_lo_r;

	// ****************
	// Quarter bit divider
	// ****************
	wire tick = qcnt_r == 16'(QTR - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			qcnt_r <= 16'h0000;
		else
			qcnt_r <= tick ? 16'h0000 : qcnt_r + 16'h0001;
	end

	// Phase 2 waits for released clock high (stretching)
	wire step = tick & ((ph_r != 2'h2) | scl_s2);
	// R5 ack drive
	// R23 ninth clock low
	wire out_bit = (cnt_r < 4'h8) ? (~tx_r | sh_r[7]) : (tx_r | ack_suppress_r);
	wire lose    = out_bit & ~sda_s2 & tx_r & (cnt_r < 4'h8);
	// R22 general call gate
	wire addr_ok = (sh_r[7:1] == own_r) |
		(gca_r & (sh_r[7:1] == 7'h00));

	// ****************
	// Bit engine
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= ST_IDLE;
			ph_r      <= 2'h0;
			cnt_r     <= 4'h0;
			sh_r      <= 8'h00;
			rx_r      <= 8'h00;
			scl_lo_r  <= 1'b0;
			sda_lo_r  <= 1'b0;
			adr_r     <= 1'b0;
			ack_val_r <= 1'b1;
			done_ev_r <= 1'b0;
			hit_ev_r  <= 1'b0;
			arb_ev_r  <= 1'b0;
			ack_ev_r  <= 1'b0;
		end else begin
			done_ev_r <= 1'b0;
			hit_ev_r  <= 1'b0;
			arb_ev_r  <= 1'b0;
			ack_ev_r  <= 1'b0;
			// R1 module enable
			if (!en_r) begin
				st_r     <= ST_IDLE;
				scl_lo_r <= 1'b0;
				sda_lo_r <= 1'b0;
			// R3 stop on clear
			end else if (mst_fall) begin
				if (is_master(st_r)) begin
					st_r <= M_STOP;
					ph_r <= 2'h0;
				end
			end else if (repeat_start_request_req && mst_r) begin
				// R6 repeated start
				if (st_r == M_HOLD) begin
					st_r <= M_RSTART;
					ph_r <= 2'h0;
				// R7 wrong time loss
				end else begin
					arb_ev_r <= 1'b1;
					st_r     <= ST_IDLE;
					scl_lo_r <= 1'b0;
					sda_lo_r <= 1'b0;
				end
			// R3 start on set
			end else if (mst_rise) begin
				if (busy_r)
					arb_ev_r <= 1'b1;
				else begin
					st_r <= M_START;
					ph_r <= 2'h0;
				end
			end else if (start_det && !is_master(st_r)) begin
				st_r     <= S_RX;
				cnt_r    <= 4'h0;
				adr_r    <= 1'b1;
				scl_lo_r <= 1'b0;
				sda_lo_r <= 1'b0;
			end else if (stop_det && !is_master(st_r)) begin
				st_r     <= ST_IDLE;
				scl_lo_r <= 1'b0;
				sda_lo_r <= 1'b0;
			end else begin
				case (st_r)
				M_START: if (step) begin
					if (ph_r == 2'h0)
						sda_lo_r <= 1'b1;
					else begin
						scl_lo_r <= 1'b1;
						adr_r    <= 1'b1;
						st_r     <= M_HOLD;
					end
					ph_r <= ph_r + 2'h1;
				end
				M_HOLD: begin
					// R19 direction match
					// R15 transmit on write
					// R21 address byte
					if (wr_data && tx_r) begin
						sh_r  <= pwdata[7:0];
						cnt_r <= 4'h0;
						ph_r  <= 2'h0;
						st_r  <= M_BIT;
					// R16 receive on read
					end else if (rd_data && !tx_r) begin
						cnt_r <= 4'h0;
						ph_r  <= 2'h0;
						st_r  <= M_BIT;
					end
				end
				M_BIT: if (step) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
					2'h0: sda_lo_r <= ~out_bit;
					2'h1: scl_lo_r <= 1'b0;
					2'h2: begin
						if (cnt_r < 4'h8)
							sh_r <= {sh_r[6:0], sda_s2};
						// R14 ack sample
						else if (tx_r) begin
							ack_ev_r  <= 1'b1;
							ack_val_r <= sda_s2;
						end
						// Loser continues as slave receiver
						if (lose) begin
							arb_ev_r <= 1'b1;
							sda_lo_r <= 1'b0;
							cnt_r    <= cnt_r + 4'h1;
							st_r     <= S_RX;
						end
					end
					default: begin
						scl_lo_r <= 1'b1;
						cnt_r    <= cnt_r + 4'h1;
						if (cnt_r == 4'h8) begin
							done_ev_r <= 1'b1;
							sda_lo_r  <= 1'b0;
							adr_r     <= 1'b0;
							st_r      <= M_HOLD;
							if (!tx_r)
								rx_r <= sh_r;
						end
					end
					endcase
				end
				M_STOP: if (step) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
					2'h0: begin
						scl_lo_r <= 1'b1;
						sda_lo_r <= 1'b1;
					end
					2'h1: scl_lo_r <= 1'b0;
					default: begin
						sda_lo_r <= 1'b0;
						st_r     <= ST_IDLE;
					end
					endcase
				end
				M_RSTART: if (step) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
					2'h0: begin
						scl_lo_r <= 1'b1;
						sda_lo_r <= 1'b0;
					end
					2'h1: scl_lo_r <= 1'b0;
					2'h2: sda_lo_r <= 1'b1;
					default: begin
						scl_lo_r <= 1'b1;
						adr_r    <= 1'b1;
						st_r     <= M_HOLD;
					end
					endcase
				end
				S_RX: begin
					if (scl_rise && cnt_r < 4'h8) begin
						sh_r  <= {sh_r[6:0], sda_s2};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						if (adr_r) begin
							// R9 address compare
							if (addr_ok) begin
								sda_lo_r <= 1'b1;
								hit_ev_r <= 1'b1;
								st_r     <= S_ACK;
							end else
								st_r <= ST_IDLE;
						end else begin
							// R20 keep received byte
							rx_r     <= sh_r;
							sda_lo_r <= ~ack_suppress_r;
							st_r     <= S_ACK;
						end
					end
				end
				S_ACK: if (scl_fall) begin
					sda_lo_r  <= 1'b0;
					scl_lo_r  <= 1'b1;
					done_ev_r <= 1'b1;
					adr_r     <= 1'b0;
					st_r      <= S_HOLD;
				end
				S_HOLD: begin
					// R18 slave data access
					if (wr_data && tx_r) begin
						sh_r     <= pwdata[7:0];
						sda_lo_r <= ~pwdata[7];
						scl_lo_r <= 1'b0;
						cnt_r    <= 4'h0;
						st_r     <= S_TX;
					end else if (rd_data && !tx_r) begin
						scl_lo_r <= 1'b0;
						cnt_r    <= 4'h0;
						st_r     <= S_RX;
					end
				end
				S_TX: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'h8) begin
							ack_ev_r  <= 1'b1;
							ack_val_r <= sda_s2;
						end
					end else if (scl_fall) begin
						if (cnt_r < 4'h8) begin
							sh_r     <= {sh_r[6:0], 1'b0};
							sda_lo_r <= ~sh_r[6];
						end else if (cnt_r == 4'h8)
							sda_lo_r <= 1'b0;
						else begin
							done_ev_r <= 1'b1;
							if (!ack_val_r) begin
								scl_lo_r <= 1'b1;
								st_r     <= S_HOLD;
							end else
								st_r <= ST_IDLE;
						end
					end
				end
				default: ;
				endcase
			end
		end
	end

	// ****************
	// Control registers
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{en_r, ie_r, tx_r, ack_suppress_r} <= {CTRL_RST[CTRL_EN],
				CTRL_RST[CTRL_IE], CTRL_RST[CTRL_TX],
				CTRL_RST[CTRL_ACK_SUPPRESS]};
			mst_r <= CTRL_RST[CTRL_MST];
			gca_r <= 1'b0;
			own_r <= OWN_RST[7:1];
		end else begin
			if (wr_ctrl) begin
				en_r   <= pwdata[CTRL_EN];
				ie_r   <= pwdata[CTRL_IE];
				tx_r   <= pwdata[CTRL_TX];
				ack_suppress_r <= pwdata[CTRL_ACK_SUPPRESS];
			end
			// R3 back to slave
			if (arb_ev_r)
				mst_r <= 1'b0;
			else if (wr_ctrl)
				mst_r <= pwdata[CTRL_MST];
			if (wr && hit_ctl2)
				gca_r <= pwdata[C2_GCA];
			if (wr && hit_own)
				own_r <= pwdata[7:1];
		end
	end

	// ****************
	// Status flags, set wins over clear
	// ****************
	wire tcf_clr = (rd_data & ~tx_r) | (wr_data & tx_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{tcf_r, own_address_hit_r, busy_r, arbitration_lost_flag_r} <= 4'h0;
			{srw_r, iif_r, ack_missing_r} <= 3'h0;
		end else begin
			// R8 byte done
			tcf_r  <= done_ev_r | (tcf_r & ~tcf_clr);
			// R9 hit flag
			own_address_hit_r <= hit_ev_r | (own_address_hit_r & ~wr_ctrl);
			// R10 bus busy
			busy_r <= start_det | (busy_r & ~stop_det);
			// R11 loss flag
			arbitration_lost_flag_r <= arb_ev_r |
				(arbitration_lost_flag_r & ~(wr_stat & pwdata[ST_ARBITRATION_LOST_FLAG]));
			// R13 pending flag
			iif_r  <= done_ev_r | hit_ev_r | arb_ev_r |
				(iif_r & ~(wr_stat & pwdata[ST_IIF]));
			// R12 capture direction
			if (hit_ev_r)
				srw_r <= sh_r[0];
			// R14 record ack
			if (ack_ev_r)
				ack_missing_r <= ack_val_r;
		end
	end

	// R24 interrupt gate
	// R2 enable gate
	assign irq = iif_r & ie_r;
endmodule : iicr_regs
`default_nettype wire

// file: shared/iicr_pkg.sv
// Purpose: Constants for the two-wire bus register block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Shared by design and bench
`default_nettype none
package iicr_pkg;
	// ****************
	// Register map
	// ****************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_CTL2 = 8'h0C;
	localparam logic [7:0] OFF_OWN  = 8'h10;
	// ****************
	// Field positions
	// ****************
	localparam int CTRL_EN   = 7;
	localparam int CTRL_IE   = 6;
	localparam int CTRL_MST  = 5;
	localparam int CTRL_TX   = 4;
	localparam int CTRL_ACK_SUPPRESS = 3;
	localparam int CTRL_REPEAT_START_REQUEST = 2;
	localparam int ST_ARBITRATION_LOST_FLAG   = 4;
	localparam int ST_IIF    = 1;
	localparam int C2_GCA    = 7;
	// ****************
	// Reset values
	// ****************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OWN_RST  = 8'h00;
	// ****************
	// Timing
	// ****************
	localparam int CLK_NS     = 5;
	localparam int SCL_PER_NS = 10000;
	localparam int QTR_CYC    = SCL_PER_NS / (4 * CLK_NS);
	// ****************
	// Engine states
	// ****************
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		M_START  = 4'h1,
		M_HOLD   = 4'h2,
		M_BIT    = 4'h3,
		M_STOP   = 4'h4,
		M_RSTART = 4'h5,
		S_RX     = 4'h6,
		S_ACK    = 4'h7,
		S_TX     = 4'h8,
		S_HOLD   = 4'h9
	} iicr_state_e;
endpackage : iicr_pkg
`default_nettype wire

// file: test/iicr_regs_assertions.sv
// Purpose: Port-level checks on the bus register block
// Assumes: Zero-wait APB, bench keeps the bus idle before starts
// Notes:   Control bits shadowed from APB writes
`default_nettype none
module iicr_regs_chk
	import iicr_pkg::*;
#(
	parameter int QTR = QTR_CYC
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe_n,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_n,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic en_r;
	logic ie_r;
	logic mst_r;
	wire  acc  = psel && penable;
	wire  wr_c = acc && pwrite && paddr == OFF_CTRL;
	wire  wr_s = acc && pwrite && paddr == OFF_STAT;
	wire  rd_c = acc && !pwrite && paddr == OFF_CTRL;
	wire  su_s = psel && !penable && !pwrite && paddr == OFF_STAT;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r  <= 1'b0;
			ie_r  <= 1'b0;
			mst_r <= 1'b0;
		end else if (wr_c) begin
			en_r  <= pwdata[CTRL_EN];
			ie_r  <= pwdata[CTRL_IE];
			mst_r <= pwdata[CTRL_MST];
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_irq_gate: assert property (!ie_r |-> !irq)
		else $error("irq high while gate off");
	chk_irq_clear: assert property (
		wr_s && pwdata[ST_IIF] |=> !irq)
		else $error("irq stays after pending clear");
	chk_repeat_start_request_zero: assert property (
		rd_c |-> prdata[2:0] == 3'h0)
		else $error("control low bits read nonzero");
	chk_off_release: assert property (
		!en_r && !$past(en_r) |-> scl_oe_n && sda_oe_n)
		else $error("lines pulled while disabled");
	chk_start_cond: assert property (
		wr_c && pwdata[CTRL_EN] && pwdata[CTRL_MST] && !mst_r
		&& scl_i && sda_i |-> ##[1:20] (scl_oe_n && !sda_oe_n))
		else $error("no start after master select");
	chk_stop_cond: assert property (
		wr_c && !pwdata[CTRL_MST] && mst_r
		|-> ##[1:60] ($rose(sda_oe_n) && scl_i))
		else $error("no stop after master clear");
	chk_arbitration_lost_flag_clear: assert property (
		wr_s && pwdata[ST_ARBITRATION_LOST_FLAG] ##[1:2] su_s |=> !prdata[4])
		else $error("lost flag not cleared");
	chk_hit_clear: assert property (
		wr_c ##[1:2] su_s |=> !prdata[6])
		else $error("address hit not cleared");
endmodule : iicr_regs_chk
bind iicr_regs iicr_regs_chk #(
	.QTR(QTR)
) u_chk (
	.pclk     (pclk),
	.presetn  (presetn),
	.psel     (psel),
	.penable  (penable),
	.pwrite   (pwrite),
	.paddr    (paddr),
	.pwdata   (pwdata),
	.prdata   (prdata),
	.pready   (pready),
	.pslverr  (pslverr),
	.scl_i    (scl_i),
	.scl_o    (scl_o),
	.scl_oe_n (scl_oe_n),
	.sda_i    (sda_i),
	.sda_o    (sda_o),
	.sda_oe_n (sda_oe_n),
	.irq      (irq)
);
`default_nettype wire

// file: test/iicr_peer.sv
// Purpose: Behavioural slave on the two-wire bus
// Assumes: Pull-ups on both lines, no clock stretching
// Notes:   Answers every read with one fixed byte
`default_nettype none
module iicr_peer #(
	parameter logic [6:0] ADDR = 7'h2A,
	parameter logic [7:0] TXB  = 8'hC5
) (
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_oe_n,
	output logic [7:0]      rx_byte,
	output logic [7:0]      adr_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int         cnt = -1;
	logic [7:0] sh;
	logic       first;
	logic       sel;
	logic       rd;
	initial sda_oe_n = 1'b1;
	// Start restarts count, stop idles
	always @(sda) if (scl === 1'b1) begin
		cnt = sda ? -1 : 0;
		first = 1'b1;
		sel = 1'b0;
		sda_oe_n = 1'b1;
	end
	always @(posedge scl) if (cnt >= 0) begin
		if (cnt < 8) sh = {sh[6:0], sda};
		cnt = cnt + 1;
	end
	always @(negedge scl) begin
		if (cnt == 8) begin
			if (first) begin
				adr_byte = sh;
				sel = sh[7:1] == ADDR;
				rd = sh[0];
			end else if (sel && !rd) rx_byte = sh;
			sda_oe_n = !(sel && (first || !rd));
		end else if (cnt == 9) begin
			cnt = 0;
			first = 1'b0;
			sda_oe_n = !(sel && rd) | TXB[7];
		end else if (cnt > 0 && cnt < 8 && sel && rd && !first)
			sda_oe_n = TXB[7 - cnt];
	end
endmodule : iicr_peer
`default_nettype wire

// file: test/iicr_regs_bench.sv
// Purpose: Self-checking bench of the bus register block
// Assumes: Peer at address 2A answers C5, QTR of 4 clocks
// Notes:   Arbitration case last, it leaves the bus busy
`default_nettype none
`define CHK(a, e) begin \
	total_checks++; \
	if ((a) !== (e)) begin \
		error_cnt++; \
		$display("[ERR] %0t got %h exp %h", $time, a, e); \
	end \
end
module iicr_regs_bench
	import iicr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [7:0]  q;
	logic        err_q;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         scl_o;
	wire         sda_o;
	wire         scl_oe_n;
	wire         sda_oe_n;
	wire         irq;
	wire         peer_oe_n;
	wire  [7:0]  peer_rx;
	wire  [7:0]  peer_adr;
	wire         scl_w = scl_oe_n;
	wire         sda_w = sda_oe_n & peer_oe_n;
	int          error_cnt;
	int          total_checks;
	int          cyc;
	iicr_regs #(
		.QTR(4)
	) u_dut (
		.pclk     (pclk),
		.presetn  (presetn),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.scl_i    (scl_w),
		.scl_o    (scl_o),
		.scl_oe_n (scl_oe_n),
		.sda_i    (sda_w),
		.sda_o    (sda_o),
		.sda_oe_n (sda_oe_n),
		.irq      (irq)
	);
	iicr_peer u_peer (
		.scl      (scl_w),
		.sda      (sda_w),
		.sda_oe_n (peer_oe_n),
		.rx_byte  (peer_rx),
		.adr_byte (peer_adr)
	);
	// ****************
	// Tasks
	// ****************
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		err_q = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		do apb(1'b0, OFF_STAT, 8'h00); while ((q & m) !== v);
	endtask : poll
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h14, 8'h00);
		`CHK(err_q, 1'b1)
		`CHK(q, 8'h00)
		`CHK({scl_o, sda_o}, 2'b00)
		apb(1'b0, OFF_STAT, 8'h00);
		`CHK(err_q, 1'b0)
		`CHK(q, 8'h00)
		apb(1'b1, OFF_CTRL, 8'hDC);
		apb(1'b0, OFF_CTRL, 8'h00);
		`CHK(q, 8'hD8)
		// Master write, address then data
		apb(1'b1, OFF_CTRL, 8'hF0);
		poll(8'h20, 8'h20);
		apb(1'b1, OFF_DATA, 8'h54);
		poll(8'h80, 8'h80);
		`CHK(q, 8'hA2)
		`CHK(peer_adr, 8'h54)
		`CHK(irq, 1'b1)
		apb(1'b0, OFF_DATA, 8'h00);
		apb(1'b1, OFF_STAT, 8'h12);
		apb(1'b0, OFF_STAT, 8'h00);
		`CHK(q, 8'hA0)
		`CHK(irq, 1'b0)
		apb(1'b1, OFF_DATA, 8'hA5);
		apb(1'b0, OFF_STAT, 8'h00);
		`CHK(q[7], 1'b0)
		poll(8'h80, 8'h80);
		`CHK(q, 8'hA2)
		`CHK(peer_rx, 8'hA5)
		apb(1'b1, OFF_CTRL, 8'hD0);
		poll(8'h20, 8'h00);
		// Unanswered address
		apb(1'b1, OFF_CTRL, 8'hF0);
		poll(8'h20, 8'h20);
		apb(1'b1, OFF_DATA, 8'h40);
		poll(8'h80, 8'h80);
		`CHK(q[0], 1'b1)
		apb(1'b1, OFF_CTRL, 8'hD0);
		poll(8'h20, 8'h00);
		// Master read of one byte
		apb(1'b1, OFF_CTRL, 8'hF0);
		poll(8'h20, 8'h20);
		apb(1'b1, OFF_DATA, 8'h55);
		poll(8'h80, 8'h80);
		apb(1'b1, OFF_CTRL, 8'hE8);
		apb(1'b0, OFF_DATA, 8'h00);
		`CHK(q, 8'h00)
		poll(8'h80, 8'h80);
		apb(1'b1, OFF_CTRL, 8'hC8);
		apb(1'b0, OFF_DATA, 8'h00);
		`CHK(q, 8'hC5)
		poll(8'h20, 8'h00);
		// Repeated start in mid byte
		apb(1'b1, OFF_CTRL, 8'hF0);
		poll(8'h20, 8'h20);
		apb(1'b1, OFF_DATA, 8'h54);
		apb(1'b1, OFF_CTRL, 8'hF4);
		poll(8'h10, 8'h10);
		`CHK(q[1], 1'b1)
		apb(1'b1, OFF_STAT, 8'h10);
		apb(1'b0, OFF_STAT, 8'h00);
		`CHK(q[4], 1'b0)
		complete_run();
	end
endmodule : iicr_regs_bench
`default_nettype wire
